// >>> rtl/three_wire_config_loader.sv
/*
  Serial configuration port and control pins of a frequency synthesizer.
  The host drives a slow serial clock, data and load strobe; all pins are
  asynchronous to clock and are resynchronised before use.
*/
// Operation
// R1 - On each serial clock rising edge shift data into the 32-bit register.
// R2 - Words arrive MSB first; last three bits select the target latch.
// R3 - Load strobe rising edge copies the shift register into the selected latch.
// R4 - Chip enable low powers down and tristates the pump output.
// R5 - Chip enable high powers up only if the power-down bit allows.
// R6 - RF outputs mute when pin low or the software mute bit set.
// R7 - Lock indicator high while locked, low when lock is lost; the code also holds it low while powered down.
// R8 - Test mux routes lock, scaled RF or scaled reference to its pin.
// R9 - Select code zero to five addresses latches zero to five.
// R10 - Double-buffered settings apply only after a later latch zero write.
// R11 - Host keeps strobe low while shifting, then pulses it once.
`timescale 1ns/1ps
`default_nettype none
module three_wire_config_loader
  import cfg_loader_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire cfg_loader_pkg::serial_s serial_in,
  input wire cfg_loader_pkg::analog_s analog_in,
  input wire logic chip_enable,
  input wire logic rf_output_on_n,
  output logic powered_up,
  output logic pump_output_enable,
  output logic rf_output_active,
  output logic lock_indicator,
  output logic test_mux_output,
  output logic [DBUF_WIDTH-1:0] active_setting,
  output logic [LATCH_COUNT*WORD_WIDTH-1:0] latch_image
);
  import cfg_loader_pkg::*;

  logic [2:0] sclk_sync;
  logic [2:0] strobe_sync;
  logic [1:0] data_sync;
  logic [1:0] ce_sync;
  logic [1:0] rfon_sync;
  logic [1:0] lock_sync;
  logic [1:0] rfs_sync;
  logic [1:0] refs_sync;
  logic [WORD_WIDTH-1:0] shift_reg;
  logic [WORD_WIDTH-1:0] latches [LATCH_COUNT];

  // Stage zero of each synchroniser feeds only stage one; edges use stages one and two.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sclk_sync <= 3'h0;
      strobe_sync <= 3'h0;
      data_sync <= 2'h0;
      ce_sync <= 2'h0;
      rfon_sync <= 2'h0;
      lock_sync <= 2'h0;
      rfs_sync <= 2'h0;
      refs_sync <= 2'h0;
    end
    else
    begin
      sclk_sync <= {sclk_sync[1:0], serial_in.serial_clock};
      strobe_sync <= {strobe_sync[1:0], serial_in.load_strobe};
      data_sync <= {data_sync[0], serial_in.serial_data};
      ce_sync <= {ce_sync[0], chip_enable};
      rfon_sync <= {rfon_sync[0], rf_output_on_n};
      lock_sync <= {lock_sync[0], analog_in.lock_raw};
      rfs_sync <= {rfs_sync[0], analog_in.rf_scaled};
      refs_sync <= {refs_sync[0], analog_in.ref_scaled};
    end
  end

  // Data is delayed as much as clock stage one, so it is sampled as it stood when the edge was first seen.
  wire sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  wire strobe_rise = strobe_sync[1] & ~strobe_sync[2];
  wire [SELECT_WIDTH-1:0] select_code = shift_reg[SELECT_WIDTH-1:0]; // R2
  wire select_valid = select_code < SELECT_WIDTH'(LATCH_COUNT); // R9
  wire load_r0 = strobe_rise && select_code == SELECT_R0; // R10

  // A word load is two steps: a strobe edge carrying a code, then the copy one clock later.
  sequence s_load_to(logic [SELECT_WIDTH-1:0] code);
    strobe_rise && select_code == code;
  endsequence

  // A serial edge moves every bit up one place and takes the synchronised data at the bottom.
  sequence s_bit_taken;
    shift_reg == {$past(shift_reg[WORD_WIDTH-2:0]), $past(data_sync[1])};
  endsequence

  always_ff @(posedge clock)
  begin
    if (reset)
      shift_reg <= LATCH_RESET;
    else if (sclk_rise)
      shift_reg <= {shift_reg[WORD_WIDTH-2:0], data_sync[1]}; // R1 R2
  end

  // Codes six and seven are ignored: nothing is written.
  genvar gi;
  generate
    for (gi = 0; gi < LATCH_COUNT; gi++)
    begin : g_latch
      always_ff @(posedge clock)
      begin
        if (reset)
          latches[gi] <= LATCH_RESET;
        else if (strobe_rise && select_valid && select_code == SELECT_WIDTH'(gi))
          latches[gi] <= shift_reg; // R3 R9
      end
      assign latch_image[gi*WORD_WIDTH +: WORD_WIDTH] = latches[gi];

      a_latch_entry: assert property (@(posedge clock) disable iff (reset) // R3 R9
        s_load_to(SELECT_WIDTH'(gi)) |=> latches[gi] == $past(shift_reg))
        else $error("A latch missed its own load.");
    end
  endgenerate

  // Register one holds the buffered setting; it reaches the core only on a register zero load.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      active_setting <= '0;
    end
    else
    begin
      if (load_r0)
        active_setting <= latches[1][DBUF_LSB +: DBUF_WIDTH]; // R10
    end
  end

  wire soft_power_down = latches[2][PD_BIT];
  wire soft_mute = latches[4][MUTE_BIT];
  wire [1:0] mux_sel = latches[2][MUX_LSB +: 2];
  wire next_powered = ce_sync[1] & ~soft_power_down; // R4 R5
  wire next_rf_active = next_powered & rfon_sync[1] & ~soft_mute; // R6
  wire next_mux = (mux_sel == MUX_RF_SCALED) ? rfs_sync[1] :
                  (mux_sel == MUX_REF_SCALED) ? refs_sync[1] : lock_sync[1]; // R8

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      powered_up <= 1'b0;
      pump_output_enable <= 1'b0;
      rf_output_active <= 1'b0;
      lock_indicator <= 1'b0;
      test_mux_output <= 1'b0;
    end
    else
    begin
      powered_up <= next_powered; // R5
      pump_output_enable <= next_powered; // R4
      rf_output_active <= next_rf_active; // R6
      lock_indicator <= lock_sync[1] & next_powered; // R7
      test_mux_output <= next_mux & next_powered; // R8
    end
  end

  a_shift_capture: assert property (@(posedge clock) disable iff (reset) // R1 R2
    sclk_rise |=> s_bit_taken)
    else $error("Shift register missed a serial bit.");

  a_shift_idle: assert property (@(posedge clock) disable iff (reset) // R1
    !sclk_rise |=> $stable(shift_reg))
    else $error("Shift register moved without a serial edge.");

  a_latch_load: assert property (@(posedge clock) disable iff (reset) // R3
    s_load_to(3'h3) |=> latches[3] == $past(shift_reg))
    else $error("Selected latch not loaded on strobe.");

  a_latch_hold: assert property (@(posedge clock) disable iff (reset) // R3
    !strobe_rise |=> $stable(latch_image))
    else $error("A latch changed without a strobe edge.");

  a_pump_off: assert property (@(posedge clock) disable iff (reset) // R4
    !ce_sync[1] |=> !pump_output_enable && !powered_up)
    else $error("Pump enabled while chip disabled.");

  a_power_up: assert property (@(posedge clock) disable iff (reset) // R5
    ce_sync[1] && !latches[2][PD_BIT] |=> powered_up)
    else $error("Device failed to power up.");

  a_power_bit: assert property (@(posedge clock) disable iff (reset) // R5
    soft_power_down |=> !powered_up)
    else $error("Device powered up against its power-down bit.");

  a_rf_mute: assert property (@(posedge clock) disable iff (reset) // R6
    !rfon_sync[1] || latches[4][MUTE_BIT] |=> !rf_output_active)
    else $error("RF output not muted.");

  a_lock_follow: assert property (@(posedge clock) disable iff (reset) // R7
    next_powered |=> lock_indicator == $past(lock_sync[1]))
    else $error("Lock indicator does not follow lock.");

  a_lock_low: assert property (@(posedge clock) disable iff (reset) // R7
    !lock_sync[1] |=> !lock_indicator)
    else $error("Lock indicator high while lock is lost.");

  a_mux_route: assert property (@(posedge clock) disable iff (reset) // R8
    next_powered && mux_sel == MUX_REF_SCALED |=> test_mux_output == $past(refs_sync[1]))
    else $error("Mux output misrouted.");

  a_mux_rf: assert property (@(posedge clock) disable iff (reset) // R8
    next_powered && mux_sel == MUX_RF_SCALED |=> test_mux_output == $past(rfs_sync[1]))
    else $error("Mux output does not carry the scaled RF.");

  a_bad_select: assert property (@(posedge clock) disable iff (reset) // R9
    strobe_rise && !select_valid |=> $stable(latch_image))
    else $error("Invalid select code wrote a latch.");

  a_dbuf_hold: assert property (@(posedge clock) disable iff (reset) // R10
    !load_r0 |=> $stable(active_setting))
    else $error("Buffered setting changed without register zero load.");

  a_dbuf_apply: assert property (@(posedge clock) disable iff (reset) // R10
    s_load_to(SELECT_R0) |=> active_setting == $past(latches[1][DBUF_LSB +: DBUF_WIDTH]))
    else $error("Buffered setting not applied.");

endmodule // three_wire_config_loader
`default_nettype wire

// >>> rtl/cfg_loader_pkg.sv
/*
  Shared constants and types for the three-wire configuration loader.
  Assumes a single 25 MHz system clock and synchronous active-high reset.
*/
package cfg_loader_pkg;

  localparam int WORD_WIDTH = 32;
  localparam int SELECT_WIDTH = 3;
  localparam int LATCH_COUNT = 6;
  localparam logic [2:0] SELECT_R0 = 3'h0;

  // Control word field positions, chosen for this block.
  localparam int PD_BIT = 5;
  localparam int MUTE_BIT = 6;
  localparam int MUX_LSB = 26;
  localparam int DBUF_LSB = 14;
  localparam int DBUF_WIDTH = 12;
  localparam logic [WORD_WIDTH-1:0] LATCH_RESET = 32'h0000_0000;

  // Output multiplexer selector codes.
  localparam logic [1:0] MUX_LOCK = 2'h0;
  localparam logic [1:0] MUX_RF_SCALED = 2'h1;
  localparam logic [1:0] MUX_REF_SCALED = 2'h2;

  typedef struct packed {
    logic serial_clock;
    logic serial_data;
    logic load_strobe;
  } serial_s;

  typedef struct packed {
    logic lock_raw;
    logic rf_scaled;
    logic ref_scaled;
  } analog_s;

endpackage

// >>> sim/host_model.sv
/*
  Host controller model that shifts words into the loader.
  Assumes the 25 MHz clock; the serial clock is 320 ns and idles low.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model
  import cfg_loader_pkg::*;
(
  input wire logic clock,
  output var cfg_loader_pkg::serial_s serial_out
);
  initial serial_out = '0;
  task automatic send(input logic [WORD_WIDTH-1:0] w);
    for (int i = WORD_WIDTH - 1; i >= 0; i--)
    begin
      @(posedge clock);
      serial_out.serial_clock <= 1'b0;
      serial_out.serial_data <= w[i];
      repeat (4) @(posedge clock);
      serial_out.serial_clock <= 1'b1;
      repeat (3) @(posedge clock);
    end
    @(posedge clock);
    serial_out.serial_clock <= 1'b0;
    // The data line is driven to the inverse of the last bit before the strobe.
    serial_out.serial_data <= ~w[0];
    repeat (4) @(posedge clock);
    serial_out.load_strobe <= 1'b1;
    repeat (4) @(posedge clock);
    serial_out.load_strobe <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
endmodule // host_model
`default_nettype wire

// >>> sim/tb.sv
/*
  Self-checking bench for the configuration loader.
  Assumes host_model drives the serial pins; outputs settle in 3 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cfg_loader_pkg::*;
  logic clock, reset, chip_enable, rf_on_n, pwr, pump, rf_act, lock_ind, mux;
  analog_s analog;
  serial_s serial;
  logic [DBUF_WIDTH-1:0] setting;
  logic [LATCH_COUNT*WORD_WIDTH-1:0] image;
  int err_total, samples_checked;
  host_model host_u (.clock(clock), .serial_out(serial));
  three_wire_config_loader dut_u (.clock(clock), .reset(reset), .serial_in(serial), .analog_in(analog),
    .chip_enable(chip_enable), .rf_output_on_n(rf_on_n), .powered_up(pwr), .pump_output_enable(pump),
    .rf_output_active(rf_act), .lock_indicator(lock_ind), .test_mux_output(mux),
    .active_setting(setting), .latch_image(image));
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [31:0] word_of(input int k);
    return (32'h5A3C_9000 + (k << 8)) | k;
  endfunction
  task automatic settle;
    repeat (6) @(posedge clock);
  endtask
  // Latch 1 goes before latch 0 so the buffered setting is known afterwards.
  task automatic t_latches;
    for (int k = 5; k >= 0; k--)
      host_u.send(word_of(k));
    host_u.send(32'hFFFF_FFFE);
    host_u.send(32'hFFFF_FFFF);
    settle;
    for (int k = 0; k < 6; k++)
      check(image[32*k +: 32], word_of(k));
  endtask
  task automatic t_dbuf;
    logic [31:0] w1;
    w1 = word_of(1);
    host_u.send(32'h0FFF_C001);
    settle;
    check(setting, w1[25:14]);
    host_u.send(32'h0000_0000);
    settle;
    check(setting, 32'hFFF);
  endtask
  task automatic t_power;
    for (int i = 0; i < 4; i++)
    begin
      host_u.send(32'h2 | (32'(!i[0]) << PD_BIT));
      chip_enable <= i[1];
      settle;
      check(pwr, i[1] & i[0]);
      check(pump, i[1] & i[0]);
    end
  endtask
  task automatic t_rf;
    for (int i = 0; i < 4; i++)
    begin
      host_u.send(32'h4 | (32'(i[1]) << MUTE_BIT));
      rf_on_n <= i[0];
      settle;
      check(rf_act, i[0] & !i[1]);
    end
  endtask
  task automatic t_mux;
    for (int m = 0; m < 4; m++)
      for (int v = 0; v < 2; v++)
      begin
        host_u.send((m << MUX_LSB) | 32'h2);
        analog <= {v[0], v[0], !v[0]};
        settle;
        check(mux, (m == 2) ? !v[0] : v[0]);
        check(lock_ind, v[0]);
      end
  endtask
  initial
  begin
    err_total = 0;
    samples_checked = 0;
    reset = 1'b1;
    chip_enable = 1'b1;
    rf_on_n = 1'b1;
    analog = '0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_latches;
    t_dbuf;
    t_power;
    t_rf;
    t_mux;
    tally_and_finish;
  end
  initial
  begin
    repeat (100000) @(posedge clock);
    err_total++;
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
